// *** irq_unit.v ***
/*
  two-level vectored interrupt unit for a single-cycle 8051-type core:
  eleven sources, per-source enable and priority, fixed query order,
  nesting bookkeeping, flag keeping and idle/stop wake-up.
  assumes peripheral event inputs are one-cycle pulses on clk_sys,
  ext_pins are asynchronous, and the core pulses irq_ack, reti_done and
  instr_retired for one clk_sys cycle each.
*/
// The strobed register port and the register addresses are this design's own decisions.
`include "irq_unit_defs.vh"
`default_nettype none

module irq_unit (
  // clock, reset, enable
  input  wire                 clk_sys,
  input  wire                 arst_n,
  input  wire                 clk_en,
  // register port
  input  wire [`IU_AW-1:0]    reg_addr,
  input  wire [31:0]          reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [31:0]          reg_rdata,
  // peripheral events
  input  wire                 timer0_overflow,
  input  wire                 timer1_overflow,
  input  wire                 timer2_overflow,
  input  wire                 conversion_start,
  input  wire                 conversion_end,
  input  wire                 pwm_period_pass,
  input  wire                 serial0_done,
  input  wire                 serial1_done,
  input  wire                 base_timer_overflow,
  // external pins
  input  wire [`IU_NPIN-1:0]  ext_pins,
  // core side
  output reg                  irq_req,
  output reg  [15:0]          irq_vector,
  input  wire                 irq_ack,
  input  wire                 reti_done,
  input  wire                 instr_retired,
  // power
  output wire                 idle_mode,
  output wire                 stop_mode,
  output reg                  wake,
  // interrupt to software
  output wire                 irq_out
);

  // ==================================================
  // state
  reg                 global_irq_enable_reg;
  reg [`IU_NSRC-1:0]  enable_reg;
  reg [`IU_NSRC-1:0]  prio_reg;
  reg [`IU_NSRC-1:0]  flag_reg;
  reg [`IU_NPIN-1:0]  rising_edge_select_reg;
  reg [`IU_NPIN-1:0]  falling_edge_select_reg;
  reg [`IU_NPIN-1:0]  pin_s1_reg;
  reg [`IU_NPIN-1:0]  pin_s2_reg;
  reg [`IU_NPIN-1:0]  pin_s3_reg;
  reg [2:0]           warm_reg;
  reg                 in_hi_reg;
  reg                 in_lo_reg;
  reg                 after_reti_reg;
  reg [3:0]           src_reg;
  reg                 src_hi_reg;
  reg [1:0]           pwr_reg;
  reg [`IU_NEV-1:0]   event_reg;
  reg [`IU_NEV-1:0]   evmask_reg;

  // ==================================================
  // helpers
  function [3:0] first_set;
    input [`IU_NSRC-1:0] v;
    integer i;
    begin
      first_set = 4'h0;
      for (i = `IU_NSRC - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_set = i[3:0];
        end
      end
    end
  endfunction

  function hit;
    input [`IU_AW-1:0] off;
    begin
      hit = (reg_addr == off);
    end
  endfunction

  // ==================================================
  // external pin synchronisers and edge detection
  wire [`IU_NPIN-1:0] pin_rise = pin_s2_reg & ~pin_s3_reg;
  wire [`IU_NPIN-1:0] pin_fall = ~pin_s2_reg & pin_s3_reg;
  wire [`IU_NPIN-1:0] pin_edge = {`IU_NPIN{warm_reg[2]}} &
                                 ((pin_rise & rising_edge_select_reg) |
                                  (pin_fall & falling_edge_select_reg));

  wire ext0_event = |pin_edge[`IU_G0_HI:`IU_G0_LO];
  wire ext1_event = |pin_edge[`IU_G1_HI:`IU_G1_LO];
  wire ext2_event = |pin_edge[`IU_G2_HI:`IU_G2_LO];

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_reg <= `IU_RST_PIN;
      pin_s2_reg <= `IU_RST_PIN;
      pin_s3_reg <= `IU_RST_PIN;
      warm_reg   <= 3'h0;
    end else if (clk_en) begin
      pin_s1_reg <= ext_pins;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      // no edges until the delay line holds real pin levels
      warm_reg   <= {warm_reg[1:0], 1'b1};
    end
  end

  // ==================================================
  // arbitration
  wire [`IU_NSRC-1:0] cand    = flag_reg & enable_reg &
                                {`IU_NSRC{global_irq_enable_reg}};
  wire [`IU_NSRC-1:0] cand_hi = cand & prio_reg;
  wire [`IU_NSRC-1:0] cand_lo = cand & ~prio_reg;

  reg        grant_valid;
  reg        grant_hi;
  reg [3:0]  grant_idx;

  always @* begin
    grant_valid = 1'b0;
    grant_hi    = 1'b0;
    grant_idx   = 4'h0;
    if (in_hi_reg) begin
      // nothing preempts a high routine
      grant_valid = 1'b0;
    end else if (in_lo_reg) begin
      grant_valid = |cand_hi;
      grant_hi    = 1'b1;
      grant_idx   = first_set(cand_hi);
    end else if (|cand_hi) begin
      grant_valid = 1'b1;
      grant_hi    = 1'b1;
      grant_idx   = first_set(cand_hi);
    end else begin
      grant_valid = |cand_lo;
      grant_idx   = first_set(cand_lo);
    end
  end

  wire accept = irq_ack & irq_req;
  wire req_next = grant_valid & ~after_reti_reg & ~accept & ~reti_done;
  wire [15:0] vec_next = `IU_VEC_BASE +
                         {9'h000, grant_idx, 3'h0};

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_req    <= 1'b0;
      irq_vector <= `IU_VEC_BASE;
      src_reg    <= 4'h0;
      src_hi_reg <= 1'b0;
    end else if (clk_en) begin
      irq_req <= req_next;
      if (req_next) begin
        irq_vector <= vec_next;
        src_reg    <= grant_idx;
        src_hi_reg <= grant_hi;
      end
    end
  end

  // ==================================================
  // nesting bookkeeping
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      in_hi_reg      <= 1'b0;
      in_lo_reg      <= 1'b0;
      after_reti_reg <= 1'b0;
    end else if (clk_en) begin
      if (accept) begin
        if (src_hi_reg) begin
          in_hi_reg <= 1'b1;
        end else begin
          in_lo_reg <= 1'b1;
        end
      end else if (reti_done) begin
        // the innermost routine returns first
        if (in_hi_reg) begin
          in_hi_reg <= 1'b0;
        end else begin
          in_lo_reg <= 1'b0;
        end
      end
      if (reti_done) begin
        after_reti_reg <= 1'b1;
      end else if (instr_retired) begin
        after_reti_reg <= 1'b0;
      end
    end
  end

  // ==================================================
  // flags: set wins over every clear
  wire [`IU_NSRC-1:0] flag_set = {ext2_event, base_timer_overflow, pwm_period_pass,
                                  serial1_done, conversion_end, timer2_overflow,
                                  serial0_done, timer1_overflow, ext1_event,
                                  timer0_overflow, ext0_event};
  wire [`IU_NSRC-1:0] acc_onehot = {{(`IU_NSRC-1){1'b0}}, accept} << src_reg;
  wire [`IU_NSRC-1:0] auto_clr   = acc_onehot & `IU_AUTO_CLR_MASK;
  wire [`IU_NSRC-1:0] sw_clr     = (reg_wr && hit(`IU_OFF_FLAG)) ?
                                   reg_wdata[`IU_NSRC-1:0] : `IU_RST_SRC;
  wire [`IU_NSRC-1:0] conv_clr   = {{(`IU_NSRC-1){1'b0}}, conversion_start}
                                   << `IU_SRC_CONV;
  wire [`IU_NSRC-1:0] flag_next  = (flag_reg & ~(auto_clr | sw_clr | conv_clr)) |
                                   flag_set;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= `IU_RST_SRC;
    end else if (clk_en) begin
      flag_reg <= flag_next;
    end
  end

  // ==================================================
  // power modes and wake-up
  wire stop_wake = pwr_reg[`IU_PWR_STOP] &
                   |(flag_reg & enable_reg & `IU_STOP_WAKE_MASK);
  wire idle_wake = pwr_reg[`IU_PWR_IDLE] & ~pwr_reg[`IU_PWR_STOP] &
                   |(flag_reg & enable_reg);

  assign idle_mode = pwr_reg[`IU_PWR_IDLE];
  assign stop_mode = pwr_reg[`IU_PWR_STOP];

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwr_reg <= `IU_RST_PWR;
      wake    <= 1'b0;
    end else if (clk_en) begin
      wake <= stop_wake | idle_wake;
      if (reg_wr && hit(`IU_OFF_POWER)) begin
        pwr_reg <= reg_wdata[1:0];
      end else if (stop_wake | idle_wake) begin
        pwr_reg <= `IU_RST_PWR;
      end
    end
  end

  // ==================================================
  // event status for software, cleared by reading it
  wire [`IU_NEV-1:0] ev_set = {accept, idle_wake, stop_wake};
  wire [`IU_NEV-1:0] ev_clr = {`IU_NEV{reg_rd && hit(`IU_OFF_EVENT)}};

  assign irq_out = |(event_reg & evmask_reg);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      event_reg <= `IU_RST_EV;
    end else if (clk_en) begin
      event_reg <= (event_reg & ~ev_clr) | ev_set;
    end
  end

  // ==================================================
  // register writes
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      global_irq_enable_reg   <= 1'b0;
      enable_reg              <= `IU_RST_SRC;
      prio_reg                <= `IU_RST_SRC;
      rising_edge_select_reg  <= `IU_RST_PIN;
      falling_edge_select_reg <= `IU_RST_PIN;
      evmask_reg              <= `IU_RST_EV;
    end else if (clk_en && reg_wr) begin
      if (hit(`IU_OFF_GLOBAL)) begin
        global_irq_enable_reg <= reg_wdata[0];
      end
      if (hit(`IU_OFF_ENABLE)) begin
        enable_reg <= reg_wdata[`IU_NSRC-1:0];
      end
      if (hit(`IU_OFF_PRIO)) begin
        prio_reg <= reg_wdata[`IU_NSRC-1:0];
      end
      if (hit(`IU_OFF_RISE)) begin
        rising_edge_select_reg <= reg_wdata[`IU_NPIN-1:0];
      end
      if (hit(`IU_OFF_FALL)) begin
        falling_edge_select_reg <= reg_wdata[`IU_NPIN-1:0];
      end
      if (hit(`IU_OFF_EVMASK)) begin
        evmask_reg <= reg_wdata[`IU_NEV-1:0];
      end
    end
  end

  // ==================================================
  // register reads, data valid the cycle after the strobe
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      `IU_OFF_GLOBAL: rd_mux = {31'h0, global_irq_enable_reg};
      `IU_OFF_ENABLE: rd_mux = {21'h0, enable_reg};
      `IU_OFF_PRIO:   rd_mux = {21'h0, prio_reg};
      `IU_OFF_FLAG:   rd_mux = {21'h0, flag_reg};
      `IU_OFF_RISE:   rd_mux = {18'h0, rising_edge_select_reg};
      `IU_OFF_FALL:   rd_mux = {18'h0, falling_edge_select_reg};
      `IU_OFF_STATE:  rd_mux = {23'h0, src_hi_reg, src_reg, irq_req,
                                after_reti_reg, in_lo_reg, in_hi_reg};
      `IU_OFF_POWER:  rd_mux = {30'h0, pwr_reg};
      `IU_OFF_EVENT:  rd_mux = {29'h0, event_reg};
      `IU_OFF_EVMASK: rd_mux = {29'h0, evmask_reg};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (reg_rd) begin
        reg_rdata <= rd_mux;
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

endmodule

`default_nettype wire

// *** irq_unit_defs.vh ***
/*
  constants of the vectored interrupt unit: register offsets, source
  indices, vector layout, field positions and reset values.
  assumes it is included by bare name into a plain verilog-2005 design.
*/
`ifndef IRQ_UNIT_DEFS_VH
`define IRQ_UNIT_DEFS_VH

// ==================================================
// sizes
`define IU_NSRC          11
`define IU_NPIN          14
`define IU_AW            8

// ==================================================
// register offsets (byte addresses, one word each)
`define IU_OFF_GLOBAL    8'h00
`define IU_OFF_ENABLE    8'h04
`define IU_OFF_PRIO      8'h08
`define IU_OFF_FLAG      8'h0c
`define IU_OFF_RISE      8'h10
`define IU_OFF_FALL      8'h14
`define IU_OFF_STATE     8'h18
`define IU_OFF_POWER     8'h1c
`define IU_OFF_EVENT     8'h20
`define IU_OFF_EVMASK    8'h24

// ==================================================
// source indices, equal to query order minus one
`define IU_SRC_EXT0      0
`define IU_SRC_T0        1
`define IU_SRC_EXT1      2
`define IU_SRC_T1        3
`define IU_SRC_SER0      4
`define IU_SRC_T2        5
`define IU_SRC_CONV      6
`define IU_SRC_SER1      7
`define IU_SRC_PWM       8
`define IU_SRC_BTM       9
`define IU_SRC_EXT2      10

// ==================================================
// vectors: base plus step times index
`define IU_VEC_BASE      16'h0003
`define IU_VEC_SHIFT     3

// flags cleared by hardware on vectoring
`define IU_AUTO_CLR_MASK 11'h70f
// sources able to leave stop mode
`define IU_STOP_WAKE_MASK 11'h605

// ==================================================
// external pin groups
`define IU_G0_LO         0
`define IU_G0_HI         3
`define IU_G1_LO         4
`define IU_G1_HI         7
`define IU_G2_LO         8
`define IU_G2_HI         13

// ==================================================
// field positions
`define IU_PWR_IDLE      0
`define IU_PWR_STOP      1
`define IU_EV_STOP_WAKE  0
`define IU_EV_IDLE_WAKE  1
`define IU_EV_ACCEPT     2
`define IU_NEV           3

// ==================================================
// reset values
`define IU_RST_SRC       11'h000
`define IU_RST_PIN       14'h0000
`define IU_RST_EV        3'h0
`define IU_RST_PWR       2'h0

`endif

// *** irq_unit_sva.sv ***
/*
  port checker of the vectored interrupt unit.
  assumes it is bound to every irq_unit instance, one clock, active-low reset.
*/
`default_nettype none
module irq_unit_sva (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic        clk_en,
  // register port
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_rdata,
  // core side and power
  input wire logic        irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic        irq_ack,
  input wire logic        reti_done,
  input wire logic        instr_retired,
  input wire logic        wake,
  input wire logic        idle_mode,
  input wire logic        stop_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ==================================================
  // assertions
  vec_range_a: assert property (irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 16'h0053)
    else $error("vector off the grid");
  ack_drop_a: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("request held after ack");
  reti_gap_a: assert property (reti_done && !instr_retired ##1 !instr_retired |=> !irq_req)
    else $error("grant before an instruction retired");
  rd_idle_a: assert property (clk_en && !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  rd_unmapped_a: assert property (clk_en && reg_rd && reg_addr > 8'h24 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  state_req_a: assert property (clk_en && reg_rd && reg_addr == 8'h18
    |=> reg_rdata[3] == $past(irq_req) && reg_rdata[7:4] <= 4'ha)
    else $error("state word disagrees");
  wake_pulse_a: assert property (wake |=> !wake)
    else $error("wake longer than a cycle");
  wake_mode_a: assert property (wake && !$past(reg_wr) |-> !idle_mode && !stop_mode)
    else $error("mode kept after wake");
endmodule
bind irq_unit irq_unit_sva u_sva (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack), .reti_done(reti_done),
  .instr_retired(instr_retired), .wake(wake), .idle_mode(idle_mode), .stop_mode(stop_mode));
`default_nettype wire

// *** core_model.sv ***
/*
  core model: acks requests promptly or slowly, runs each routine 12 cycles.
  assumes the request/ack/return handshake of irq_unit on clk_sys.
*/
`default_nettype none
module core_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // request side
  input  wire logic irq_req,
  input  wire logic slow,
  output logic      irq_ack,
  output logic      reti_done,
  output logic      instr_retired
);
  timeunit 1ns;
  timeprecision 1ns;
  int depth, lag, hold;
  int rem[2];
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {irq_ack, reti_done, instr_retired} <= 3'h0;
      depth <= 0;
      lag <= 0;
      hold <= 0;
    end else begin
      irq_ack <= 1'b0;
      reti_done <= 1'b0;
      instr_retired <= (hold == 0);
      if (hold > 0) hold <= hold - 1;
      if (irq_req && !irq_ack && depth < 2 && lag >= (slow ? 3 : 0)) begin
        irq_ack <= 1'b1;
        rem[depth] <= 12;
        depth <= depth + 1;
        lag <= 0;
      end else begin
        lag <= irq_req ? lag + 1 : 0;
        if (depth > 0 && rem[depth-1] == 0) begin
          reti_done <= 1'b1;
          instr_retired <= 1'b0;
          depth <= depth - 1;
          hold <= 2;
        end else if (depth > 0) rem[depth-1] <= rem[depth-1] - 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** two_level_vectored_interrupt_unit_tb.sv ***
/*
  self-checking bench of irq_unit with a core model on the request side.
  assumes the unit's register map and a 100 MHz clock.
*/
`default_nettype none
module two_level_vectored_interrupt_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, arst_n, reg_wr, reg_rd, conv_start, slow, clk_en, nv;
  logic        irq_req, irq_ack, reti_done, instr_retired, idle_mode, stop_mode, wake, irq_out;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [10:0] ev;
  logic [13:0] ext_pins;
  logic [15:0] irq_vector;
  logic [15:0] acked_q[$];
  int          err_count, n_tests, i, off, pin, grp;
  int          wake_cnt, wake_base;
  int e1[4] = '{3, 1, 5, 1};
  int e2[4] = '{5, 5, 1, 3};
  int lo[4] = '{6, 0, 6, 6};
  int hi[4] = '{30, 6, 30, 30};
  int pm[4] = '{2, 2, 2, 1};
  int ps[4] = '{1, 9, 10, 1};
  irq_unit u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer0_overflow(ev[1]), .timer1_overflow(ev[3]), .timer2_overflow(ev[5]),
    .conversion_start(conv_start), .conversion_end(ev[6]), .pwm_period_pass(ev[8]),
    .serial0_done(ev[4]), .serial1_done(ev[7]), .base_timer_overflow(ev[9]),
    .ext_pins(ext_pins), .irq_req(irq_req), .irq_vector(irq_vector), .irq_ack(irq_ack),
    .reti_done(reti_done), .instr_retired(instr_retired), .idle_mode(idle_mode),
    .stop_mode(stop_mode), .wake(wake), .irq_out(irq_out));
  core_model u_core (.clk_sys(clk_sys), .arst_n(arst_n), .irq_req(irq_req), .slow(slow),
    .irq_ack(irq_ack), .reti_done(reti_done), .instr_retired(instr_retired));
  // ==================================================
  // clock, monitors, watchdog
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (irq_req && irq_ack) acked_q.push_back(irq_vector);
    if (wake) wake_cnt <= wake_cnt + 1;
  end
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  // ==================================================
  // tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask
  // external sources toggle one pin of their group, both edges selected
  task automatic fire(input logic [10:0] m);
    ext_pins <= ext_pins ^ ({13'h0, m[0]} | {9'h0, m[2], 4'h0} | {5'h0, m[10], 8'h0});
    ev <= m & 11'h3fa;
    @(posedge clk_sys);
    ev <= 11'h0;
    @(posedge clk_sys);
  endtask
  task automatic chk_ack(input int src, input int lo_c, input int hi_c);
    repeat (lo_c) @(posedge clk_sys);
    if (lo_c > 0) chk(32'(acked_q.size()), 0, "early grant");
    for (int k = 0; k < hi_c && acked_q.size() == 0; k++) @(posedge clk_sys);
    chk(acked_q.size() ? 32'(acked_q.pop_front()) : 'x, 32'h3 + 32'(8 * src), "vector");
  endtask
  // ==================================================
  // tests
  initial begin
    {arst_n, reg_wr, reg_rd, conv_start, slow} = 5'h0;
    clk_en = 1'b1;
    {reg_addr, reg_wdata, ev, ext_pins} = '0;
    void'($urandom(23075));
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    for (int a = 0; a <= 'h28; a += 4) begin
      rd(8'(a), rv);
      chk(rv, 32'h0, "reset value");
    end
    // a write while the clock enable is low must not land
    clk_en <= 1'b0;
    wr(8'h08, 32'h7ff);
    clk_en <= 1'b1;
    rd(8'h08, rv);
    chk(rv, 32'h0, "write while frozen");
    $display("reset values done");
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h7ff);
    wr(8'h10, 32'h3fff);
    wr(8'h14, 32'h3fff);
    wr(8'h24, 32'h4);
    fire(11'h2);
    chk_ack(1, 0, 20);
    repeat (2) @(posedge clk_sys);
    chk(irq_out, 1, "irq level");
    rd(8'h20, rv);
    chk(rv, 32'h4, "event status");
    chk(irq_out, 0, "irq after read");
    wr(8'h24, 32'h0);
    repeat (20) @(posedge clk_sys);
    $display("interrupt line done");
    off = $urandom_range(10);
    for (int k = 0; k < 11; k++) begin
      i = (k + off) % 11;
      slow <= 1'($urandom);
      fire(11'h1 << i);
      chk_ack(i, 0, 30);
      rd(8'h0c, rv);
      chk(rv, (i >= 4 && i <= 7) ? 32'h1 << i : 32'h0, "flag after vectoring");
      wr(8'h0c, 32'h7ff);
      repeat (20) @(posedge clk_sys);
    end
    $display("vectors done");
    slow <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      wr(8'h08, (r == 1 || r == 2) ? 32'h20 : 32'h0);
      fire(r == 0 ? (11'h1 << e1[r]) | (11'h1 << e2[r]) : 11'h1 << e1[r]);
      chk_ack(e1[r], 0, 20);
      wr(8'h0c, 32'h1 << e1[r]);
      if (r != 0) fire(11'h1 << e2[r]);
      chk_ack(e2[r], lo[r], hi[r]);
      wr(8'h0c, 32'h1 << e2[r]);
      repeat (30) @(posedge clk_sys);
    end
    wr(8'h08, 32'h0);
    $display("priority done");
    for (int g = 0; g < 2; g++) begin
      wr(g ? 8'h00 : 8'h04, g ? 32'h0 : 32'h7fd);
      fire(11'h2);
      repeat (12) @(posedge clk_sys);
      chk(32'(acked_q.size()), 0, "gated grant");
      wr(g ? 8'h00 : 8'h04, g ? 32'h1 : 32'h7ff);
      chk_ack(1, 0, 20);
      repeat (20) @(posedge clk_sys);
    end
    wr(8'h00, 32'h0);
    for (int m = 1; m < 4; m++) begin
      pin = $urandom_range(13);
      grp = pin < 4 ? 0 : pin < 8 ? 2 : 10;
      wr(8'h10, 32'(m % 2) << pin);
      wr(8'h14, 32'(m / 2) << pin);
      repeat (2) begin
        nv = ~ext_pins[pin];
        ext_pins[pin] <= nv;
        repeat (6) @(posedge clk_sys);
        rd(8'h0c, rv);
        chk(rv, (nv ? m % 2 : m / 2) ? 32'h1 << grp : 32'h0, "edge select");
        wr(8'h0c, 32'h7ff);
      end
    end
    fire(11'h40);
    rd(8'h0c, rv);
    chk(rv, 32'h40, "conversion flag set");
    conv_start <= 1'b1;
    @(posedge clk_sys);
    conv_start <= 1'b0;
    rd(8'h0c, rv);
    chk(rv, 32'h0, "conversion flag cleared");
    $display("flags done");
    wr(8'h10, 32'h3fff);
    wr(8'h14, 32'h3fff);
    for (int r = 0; r < 4; r++) begin
      wake_base = wake_cnt;
      wr(8'h1c, 32'(pm[r]));
      fire(11'h1 << ps[r]);
      repeat (8) @(posedge clk_sys);
      chk(32'(wake_cnt - wake_base), 32'(ps[r] != 1 || pm[r] == 1), "wake");
      chk({stop_mode, idle_mode}, (ps[r] != 1 || pm[r] == 1) ? 0 : pm[r], "mode");
      wr(8'h0c, 32'h7ff);
      wr(8'h1c, 32'h0);
    end
    $display("power done");
    chk(32'(acked_q.size()), 0, "stray grant");
    tally_and_finish();
  end
endmodule
`default_nettype wire
